// *** hdl/twe_dpram.sv ***
// Purpose: Dual-clock memory, one write port and one registered read port
// Assumes: Each port is used only in its own clock domain
// Notes: No reset on the array; contents hold while powered
`default_nettype none

module twe_dpram #(
  parameter int AW = 6,
  parameter int DW = 8
) (
  input wire logic i_wclk,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [DW-1:0] i_wdata,
  input wire logic i_rclk,
  input wire logic [AW-1:0] i_raddr,
  output logic [DW-1:0] o_rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [DW-1:0] rdata_r;

  always_ff @(posedge i_wclk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_rclk) begin
    rdata_r <= mem[i_raddr];
  end

  assign o_rdata = rdata_r;

endmodule // twe_dpram

`default_nettype wire

// *** hdl/twe_pkg.sv ***
// Purpose: Shared constants and types for the two-wire memory target
// Assumes: 100 MHz system clock
// Notes: Bus-side timing is counted in bits of the bus clock
`default_nettype none

package twe_pkg;

  // ----------------------------------------------------------------
  // Clock and programming time
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned PROG_TIME_MS = 5;
  localparam int unsigned PROG_CYCLES = PROG_TIME_MS * 1000 * CLK_MHZ;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int ARRAY_AW = 15;
  localparam int PAGE_AW = 6;
  localparam int BYTE_W = 8;
  localparam logic [PAGE_AW:0] PAGE_BYTES = 7'h40;

  // ----------------------------------------------------------------
  // Protocol fields
  // ----------------------------------------------------------------
  localparam logic [3:0] DEV_TYPE = 4'hA;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  // Start arrives through a synchroniser; four bits are already shifted in
  localparam logic [3:0] START_BIT_NXT = 4'h5;

  typedef enum logic [2:0] {
    L_IDLE = 3'b000,
    L_DEV = 3'b001,
    L_WHI = 3'b010,
    L_WLO = 3'b011,
    L_WDAT = 3'b100,
    L_RDAT = 3'b101
  } twe_lnk_t;

  typedef enum logic {
    P_IDLE = 1'b0,
    P_PROG = 1'b1
  } twe_prog_t;

endpackage

`default_nettype wire

// *** hdl/twe_sync.sv ***
// Purpose: Three-stage level synchroniser with agreement filter
// Assumes: Inputs are levels that hold for several destination edges
// Notes: Output follows once stages two and three agree
`default_nettype none

module twe_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  // First stage feeds only the second
  always_comb begin
    q_nxt = (s2_r & s3_r) | (q_r & (s2_r | s3_r));
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r <= '0;
    end else begin
      s1_r <= i_d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r <= q_nxt;
    end
  end

  assign o_q = q_r;

endmodule // twe_sync

`default_nettype wire

// *** hdl/twe_target.sv ***
// Purpose: Two-wire bus target for a 32 Kbyte page-programmed memory
// Assumes: Bus clock high and low phases each last 100 ns or more
// Notes: Link logic runs on the bus clock; programming runs on i_clk
//
// Functional notes
// - Every start is followed by an eight-bit device address byte
// - Respond only when the top four address bits hold the type pattern
// - Next three bits must equal the three chip-select straps
// - A floating strap reads as logic low
// - Bit eight selects direction: one reads, zero writes
// - Acknowledge a match low; on mismatch stay silent and go idle
// - Write-protect high keeps the whole array unchanged
// - Write takes two address bytes then data, each acknowledged
// - Stop after a write starts the self-timed programming cycle
// - While programming, bus inputs are ignored and nothing answers
// - Page write accepts up to 64 data bytes, each acknowledged
// - Write address advances low six bits only, wrapping inside page
// - Polling address is acknowledged only after programming ends
// - Address counter holds last accessed address plus one
// - Read address wraps from array end to array start
// - Current read sends the byte at the counter after address ack
// - Controller ack fetches next byte; no ack and stop ends reading
// - Data falling while clock high is a start
// - Data rising while clock high is a stop; target goes to standby
// - Bytes are eight bits; target pulls data low on ninth clock
`default_nettype none

module twe_target import twe_pkg::*; #(
  parameter int unsigned PROG_CYCLES_P = PROG_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_wp,
  input wire logic i_strap_select_bit2,
  input wire logic i_strap_select_bit1,
  input wire logic i_strap_select_bit0,
  output logic o_sda_o,
  output logic o_sda_oe,
  output logic o_prog_busy
);

  localparam int PCW = $clog2(PROG_CYCLES_P + 1);

  // Pad pull-down: anything but a driven one counts as low
  function automatic logic pin_hi(input logic b);
    pin_hi = (b === 1'b1);
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [3:0] sys_s;
  logic scl_s;
  logic sda_s;
  logic wp_s;
  logic pend_s;
  logic scl_q_r;
  logic sda_q_r;
  logic start_ev;
  logic stop_ev;
  logic frm_tgl_r;
  logic frm_tgl_nxt;
  logic armed_r;
  logic armed_nxt;
  twe_prog_t pst_r;
  twe_prog_t pst_nxt;
  logic [PCW-1:0] pcnt_r;
  logic [PCW-1:0] pcnt_nxt;
  logic busy_r;
  logic cpy_vld_r;
  logic cpy_vld_nxt;
  logic [PAGE_AW-1:0] cpy_idx_r;
  logic [BYTE_W-1:0] pb_rdata;
  logic ar_we;

  logic lnk_rst;
  logic [4:0] lnk_s;
  logic tgl_l;
  logic busy_l;
  logic [2:0] strap_l;
  twe_lnk_t lst_r;
  twe_lnk_t lst_nxt;
  logic [3:0] bit_r;
  logic [3:0] bit_nxt;
  logic [BYTE_W-1:0] sh_r;
  logic [BYTE_W-1:0] sh_nxt;
  logic [BYTE_W-1:0] byte_in;
  logic [BYTE_W-1:0] tx_r;
  logic [BYTE_W-1:0] tx_nxt;
  logic [ARRAY_AW-1:0] addr_r;
  logic [ARRAY_AW-1:0] addr_nxt;
  logic ack_r;
  logic ack_nxt;
  logic seen_r;
  logic seen_nxt;
  logic wr_pend_r;
  logic wr_pend_nxt;
  logic [(1<<PAGE_AW)-1:0] wr_mask_r;
  logic [(1<<PAGE_AW)-1:0] wr_mask_nxt;
  logic pb_we;
  logic [BYTE_W-1:0] ar_rdata;
  logic oe_r;
  logic oe_nxt;
  logic sda_o_r;

  // ----------------------------------------------------------------
  // System domain: line watch and programming cycle
  // ----------------------------------------------------------------
  twe_sync #(.W(4)) u_sys_sync (
    .i_clk(i_clk),
    .i_rst(i_srst),
    .i_d({i_scl, i_sda, i_wp, wr_pend_r}),
    .o_q(sys_s)
  );

  assign scl_s = sys_s[3];
  assign sda_s = sys_s[2];
  assign wp_s = sys_s[1];
  assign pend_s = sys_s[0];

  assign start_ev = scl_s & scl_q_r & sda_q_r & ~sda_s;
  assign stop_ev = scl_s & scl_q_r & ~sda_q_r & sda_s;

  always_comb begin
    pst_nxt = pst_r;
    pcnt_nxt = pcnt_r;
    // Starts are swallowed while programming, so the link never wakes
    frm_tgl_nxt = frm_tgl_r ^ (start_ev & (pst_r == P_IDLE));
    // Pending flag outlives swallowed polls; only a fresh frame may commit
    armed_nxt = armed_r | (start_ev & (pst_r == P_IDLE));
    unique case (pst_r)
      P_IDLE: begin
        if (stop_ev && pend_s && armed_r && !wp_s) begin
          pst_nxt = P_PROG;
          pcnt_nxt = '0;
          armed_nxt = 1'b0;
        end
      end
      P_PROG: begin
        if (pcnt_r == PCW'(PROG_CYCLES_P - 1)) begin
          pst_nxt = P_IDLE;
        end else begin
          pcnt_nxt = pcnt_r + 1'b1;
        end
      end
    endcase
    cpy_vld_nxt = (pst_r == P_PROG) && (pcnt_r < PCW'(PAGE_BYTES));
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      frm_tgl_r <= 1'b0;
      armed_r <= 1'b0;
      pst_r <= P_IDLE;
      pcnt_r <= '0;
      busy_r <= 1'b0;
      cpy_vld_r <= 1'b0;
      cpy_idx_r <= '0;
    end else begin
      scl_q_r <= scl_s;
      sda_q_r <= sda_s;
      frm_tgl_r <= frm_tgl_nxt;
      armed_r <= armed_nxt;
      pst_r <= pst_nxt;
      pcnt_r <= pcnt_nxt;
      busy_r <= (pst_nxt == P_PROG);
      cpy_vld_r <= cpy_vld_nxt;
      cpy_idx_r <= pcnt_r[PAGE_AW-1:0];
    end
  end

  // Mask and page address are quiet: the link is idle while busy
  assign ar_we = cpy_vld_r & wr_mask_r[cpy_idx_r] & ~wp_s;

  twe_dpram #(.AW(PAGE_AW), .DW(BYTE_W)) u_page_buf (
    .i_wclk(i_scl),
    .i_we(pb_we),
    .i_waddr(addr_r[PAGE_AW-1:0]),
    .i_wdata(byte_in),
    .i_rclk(i_clk),
    .i_raddr(pcnt_r[PAGE_AW-1:0]),
    .o_rdata(pb_rdata)
  );

  twe_dpram #(.AW(ARRAY_AW), .DW(BYTE_W)) u_array (
    .i_wclk(i_clk),
    .i_we(ar_we),
    .i_waddr({addr_r[ARRAY_AW-1:PAGE_AW], cpy_idx_r}),
    .i_wdata(pb_rdata),
    .i_rclk(i_scl),
    .i_raddr(addr_r),
    .o_rdata(ar_rdata)
  );

  // ----------------------------------------------------------------
  // Link domain: byte engine on the bus clock
  // ----------------------------------------------------------------
  twe_sync #(.W(1)) u_lnk_rst (
    .i_clk(i_scl),
    .i_rst(1'b0),
    .i_d(i_srst),
    .o_q(lnk_rst)
  );

  twe_sync #(.W(5)) u_lnk_sync (
    .i_clk(i_scl),
    .i_rst(lnk_rst),
    .i_d({frm_tgl_r, busy_r, pin_hi(i_strap_select_bit2),
          pin_hi(i_strap_select_bit1), pin_hi(i_strap_select_bit0)}),
    .o_q(lnk_s)
  );

  assign tgl_l = lnk_s[4];
  assign busy_l = lnk_s[3];
  assign strap_l = lnk_s[2:0];
  assign byte_in = {sh_r[BYTE_W-2:0], i_sda};

  always_comb begin
    lst_nxt = lst_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    tx_nxt = tx_r;
    addr_nxt = addr_r;
    ack_nxt = ack_r;
    seen_nxt = seen_r;
    wr_pend_nxt = wr_pend_r;
    wr_mask_nxt = wr_mask_r;
    pb_we = 1'b0;
    if (seen_r != tgl_l) begin
      // Late start: realign mid-byte, earlier bits already shifted
      seen_nxt = tgl_l;
      lst_nxt = L_DEV;
      bit_nxt = START_BIT_NXT;
      sh_nxt = byte_in;
      ack_nxt = 1'b0;
      wr_pend_nxt = 1'b0;
      wr_mask_nxt = '0;
    end else if (bit_r == BIT_ACK) begin
      bit_nxt = '0;
      ack_nxt = 1'b0;
      unique case (lst_r)
        L_IDLE: begin
        end
        L_DEV: begin
          if (sh_r[0]) begin
            lst_nxt = L_RDAT;
            tx_nxt = ar_rdata;
            addr_nxt = addr_r + 1'b1;
          end else begin
            lst_nxt = L_WHI;
          end
        end
        L_WHI: lst_nxt = L_WLO;
        L_WLO: lst_nxt = L_WDAT;
        L_WDAT: begin
        end
        L_RDAT: begin
          if (!i_sda) begin
            tx_nxt = ar_rdata;
            addr_nxt = addr_r + 1'b1;
          end else begin
            lst_nxt = L_IDLE;
          end
        end
        default: lst_nxt = L_IDLE;
      endcase
    end else begin
      sh_nxt = byte_in;
      bit_nxt = bit_r + 1'b1;
      if (bit_r == BIT_LAST) begin
        unique case (lst_r)
          L_DEV: begin
            if (byte_in[7:4] == DEV_TYPE && byte_in[3:1] == strap_l) begin
              ack_nxt = 1'b1;
            end else begin
              lst_nxt = L_IDLE;
            end
          end
          L_WHI: begin
            ack_nxt = 1'b1;
            addr_nxt[ARRAY_AW-1:BYTE_W] = byte_in[ARRAY_AW-BYTE_W-1:0];
          end
          L_WLO: begin
            ack_nxt = 1'b1;
            addr_nxt[BYTE_W-1:0] = byte_in;
          end
          L_WDAT: begin
            ack_nxt = 1'b1;
            pb_we = 1'b1;
            wr_pend_nxt = 1'b1;
            wr_mask_nxt[addr_r[PAGE_AW-1:0]] = 1'b1;
            addr_nxt[PAGE_AW-1:0] = addr_r[PAGE_AW-1:0] + 1'b1;
          end
          default: begin
          end
        endcase
      end
    end
    if (busy_l) begin
      // Prior frame state must not answer a polling address
      lst_nxt = L_IDLE;
      ack_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_scl) begin
    if (lnk_rst) begin
      lst_r <= L_IDLE;
      bit_r <= '0;
      sh_r <= '0;
      tx_r <= '0;
      addr_r <= '0;
      ack_r <= 1'b0;
      seen_r <= 1'b0;
      wr_pend_r <= 1'b0;
      wr_mask_r <= '0;
    end else begin
      lst_r <= lst_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      tx_r <= tx_nxt;
      addr_r <= addr_nxt;
      ack_r <= ack_nxt;
      seen_r <= seen_nxt;
      wr_pend_r <= wr_pend_nxt;
      wr_mask_r <= wr_mask_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Data line drive, changed only while the clock is low
  // ----------------------------------------------------------------
  always_comb begin
    oe_nxt = (bit_r == BIT_ACK) && ack_r;
    if (lst_r == L_RDAT && bit_r < BIT_ACK) begin
      oe_nxt = !tx_r[3'(BIT_LAST - bit_r)];
    end
  end

  always_ff @(negedge i_scl) begin
    if (lnk_rst) begin
      oe_r <= 1'b0;
      sda_o_r <= 1'b0;
    end else begin
      oe_r <= oe_nxt;
      sda_o_r <= 1'b0;
    end
  end

  assign o_sda_oe = oe_r;
  assign o_sda_o = sda_o_r;
  assign o_prog_busy = busy_r;

endmodule // twe_target

`default_nettype wire

// *** verif/tb_top.sv ***
// Purpose: Self-checking bench for the two-wire target
// Assumes: Controller model owns the bus clock
// Notes: Short programming time keeps the run brief
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Harness
  // ----
  localparam int unsigned PROG_P = 100;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_wp = 1'b0;
  logic [2:0] strap = 3'h0;
  logic scl, ctl_oe, sda_o, sda_oe, busy, sda;
  logic [14:0] cur = 15'h0000;
  logic [7:0] mem [int];
  logic [31:0] seed = 32'h00000040;
  int error_cnt = 0;
  int comparisons = 0;
  assign sda = ~(ctl_oe | (sda_oe & ~sda_o));  // Pull-up
  initial forever #5 i_clk = ~i_clk;
  initial begin
    #990000;
    error_cnt++;  // Hang guard
    finish_test();
  end
  twe_target #(.PROG_CYCLES_P(PROG_P)) u_twe_target (.i_clk, .i_srst, .i_scl(scl),
    .i_sda(sda), .i_wp, .i_strap_select_bit2(strap[2]), .i_strap_select_bit1(strap[1]),
    .i_strap_select_bit0(strap[0]), .o_sda_o(sda_o), .o_sda_oe(sda_oe), .o_prog_busy(busy));
  twe_ctl_model u_twe_ctl_model (.i_sda(sda), .o_scl(scl), .o_sda_oe(ctl_oe));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (error_cnt == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic sync();
    @(posedge i_clk);
    #2;
  endtask
  task automatic snd(input logic [7:0] d, input logic exp, input string what);
    logic a;
    u_twe_ctl_model.send(d, a);
    chk(what, a, exp);
  endtask
  task automatic wr(input logic [14:0] a, input int n);
    logic [7:0] d;
    logic ok;
    sync();
    u_twe_ctl_model.start_cond();
    snd({4'hA, strap, 1'b0}, 1'b1, "dev");
    d = rnd();
    snd({d[7], a[14:8]}, 1'b1, "addr_hi");
    snd(a[7:0], 1'b1, "addr_lo");
    cur = a;
    repeat (n) begin
      d = rnd();
      snd(d, 1'b1, "data");
      if (!i_wp) mem[cur] = d;
      cur[5:0] = cur[5:0] + 6'h01;
    end
    u_twe_ctl_model.stop_cond();
    chk("busy", busy, !i_wp);
    ok = 1'b0;
    for (int k = 0; k < 8 && !ok; k++) begin
      u_twe_ctl_model.start_cond();
      u_twe_ctl_model.send({4'hA, strap, 1'b0}, ok);
      u_twe_ctl_model.stop_cond();
      if (k == 0) chk("poll", ok, i_wp);
    end
    chk("poll_end", ok, 1'b1);
  endtask
  task automatic rd(input logic [14:0] a, input int n, input logic rand_rd);
    logic [7:0] d;
    sync();
    u_twe_ctl_model.start_cond();
    if (rand_rd) begin
      snd({4'hA, strap, 1'b0}, 1'b1, "dev");
      snd({1'b0, a[14:8]}, 1'b1, "addr_hi");
      snd(a[7:0], 1'b1, "addr_lo");
      u_twe_ctl_model.start_cond();
      cur = a;
    end
    snd({4'hA, strap, 1'b1}, 1'b1, "dev_rd");
    for (int i = 0; i < n; i++) begin
      u_twe_ctl_model.recv(i < n - 1, d);
      chk("rdata", d, mem[cur]);
      cur = cur + 15'h0001;
    end
    u_twe_ctl_model.stop_cond();
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    logic [7:0] d;
    logic [14:0] base;
    sync();
    // Link logic resets on bus clock edges, so reset spans idle bits
    repeat (8) u_twe_ctl_model.put_bit(1'b1);
    @(posedge i_clk) i_srst <= 1'b0;
    #2;
    repeat (8) u_twe_ctl_model.put_bit(1'b1);
    chk("oe", sda_oe, 1'b0);
    chk("busy", busy, 1'b0);
    d = rnd();
    @(posedge i_clk) strap <= d[2:0];
    for (int s = 0; s < 9; s++) begin
      sync();
      u_twe_ctl_model.start_cond();
      snd({(s < 8) ? 4'hA : 4'h5, 3'(s), 1'b0}, s < 8 && 3'(s) == strap, "dev");
      u_twe_ctl_model.stop_cond();
    end
    base = 15'({rnd(), rnd()}) & 15'h7FC0;
    wr(base + 15'h0005, 66);
    rd(base, 10, 1'b1);
    rd(base, 54, 1'b0);
    @(posedge i_clk) i_wp <= 1'b1;
    wr(base + 15'h0003, 2);
    @(posedge i_clk) i_wp <= 1'b0;
    rd(base, 8, 1'b1);
    wr(15'h7FFF, 1);
    wr(15'h0000, 1);
    rd(15'h7FFF, 2, 1'b1);
    finish_test();
  end
endmodule // tb_top
`default_nettype wire

// *** verif/twe_ctl_model.sv ***
// Purpose: Bus controller model
// Assumes: Bench adds the pull-up
// Notes: Phases of 150 ns; clock rests between frames
`default_nettype none
module twe_ctl_model (
  input wire logic i_sda,
  output var logic o_scl,
  output var logic o_sda_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Bit tasks
  // ----
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end
  task automatic put_bit(input logic b);
    #75 o_sda_oe = ~b;
    #75 o_scl = 1'b1;
    #150 o_scl = 1'b0;
  endtask
  task automatic get_bit(output logic b);
    #75 o_sda_oe = 1'b0;
    #75 o_scl = 1'b1;
    #75 b = i_sda;
    #75 o_scl = 1'b0;
  endtask
  task automatic start_cond();
    #75 o_sda_oe = 1'b0;
    #75 o_scl = 1'b1;
    #150 o_sda_oe = 1'b1;
    #150 o_scl = 1'b0;
  endtask
  task automatic stop_cond();
    #75 o_sda_oe = 1'b1;
    #75 o_scl = 1'b1;
    #150 o_sda_oe = 1'b0;
    #150;
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(ack);
    ack = ~ack;
  endtask
  task automatic recv(input logic more, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(~more);
  endtask
endmodule // twe_ctl_model
`default_nettype wire

// *** verif/twe_target_monitor.sv ***
// Purpose: Bus checker for the two-wire target
// Assumes: Bus phases span many i_clk cycles
// Notes: Bus edges are found by oversampling
`default_nettype none
module twe_mon import twe_pkg::*; #(
  parameter int unsigned PROG_CYCLES_P = PROG_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_wp,
  input wire logic i_strap_select_bit2,
  input wire logic i_strap_select_bit1,
  input wire logic i_strap_select_bit0,
  input wire logic o_sda_o,
  input wire logic o_sda_oe,
  input wire logic o_prog_busy
);
  // ----
  // Tracker
  // ----
  logic scl_r, sda_r, wr_r, rd_r, ign_r, start, stop, rise, ack9, hit;
  logic [3:0] bc_r;
  logic [7:0] bi_r, sh_r;
  int unsigned bz_r;
  assign start = scl_r & i_scl & sda_r & ~i_sda;
  assign stop = scl_r & i_scl & ~sda_r & i_sda;
  assign rise = ~scl_r & i_scl;
  assign ack9 = rise & (bc_r == 4'h8);
  assign hit = sh_r[7:1] == {DEV_TYPE, i_strap_select_bit2, i_strap_select_bit1,
    i_strap_select_bit0};
  always_ff @(posedge i_clk) begin
    scl_r <= i_scl;
    sda_r <= i_sda;
    bz_r <= o_prog_busy ? bz_r + 1 : 0;
    if (o_prog_busy) ign_r <= 1'b1;  // Frames begun while busy go unanswered
    if (start) begin
      bc_r <= 4'h0;
      bi_r <= 8'h00;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      if (!o_prog_busy) ign_r <= 1'b0;
    end else if (ack9) begin
      bc_r <= 4'h0;
      bi_r <= bi_r + 8'h01;
      if (bi_r == 8'h00) begin
        wr_r <= hit & ~sh_r[0] & ~ign_r;
        rd_r <= hit & sh_r[0] & ~ign_r;
      end
    end else if (rise) begin
      bc_r <= bc_r + 4'h1;
      sh_r <= {sh_r[6:0], i_sda};
    end
    if (i_srst) begin
      bz_r <= 0;
      {ign_r, wr_r, rd_r, bc_r, bi_r, sh_r} <= '0;
    end
  end
  // ----
  // Properties
  // ----
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  sequence s_prog; ##[1:10] o_prog_busy; endsequence
  property p_od; o_sda_oe |-> !o_sda_o; endproperty
  a_od: assert property (p_od) else $error("data driven high");
  property p_ack; ack9 && bi_r == 8'h00 && hit && !ign_r |-> o_sda_oe; endproperty
  a_ack: assert property (p_ack) else $error("no ack on match");
  property p_nak; ack9 && bi_r == 8'h00 && !hit |-> !o_sda_oe; endproperty
  a_nak: assert property (p_nak) else $error("ack on mismatch");
  property p_wack; ack9 && wr_r |-> o_sda_oe; endproperty
  a_wack: assert property (p_wack) else $error("write byte not acked");
  property p_rfree; ack9 && rd_r |-> !o_sda_oe; endproperty
  a_rfree: assert property (p_rfree) else $error("line held in ack slot");
  property p_quiet; o_prog_busy |-> !o_sda_oe; endproperty
  a_quiet: assert property (p_quiet) else $error("answer while busy");
  property p_go; stop && wr_r && bi_r >= 8'h04 && !i_wp |-> s_prog; endproperty
  a_go: assert property (p_go) else $error("no programming");
  property p_wp; stop && wr_r && i_wp |=> !o_prog_busy [*8]; endproperty
  a_wp: assert property (p_wp) else $error("protected write ran");
  property p_len; $fell(o_prog_busy) |-> bz_r == PROG_CYCLES_P; endproperty
  a_len: assert property (p_len) else $error("program time wrong");
endmodule // twe_mon
bind twe_target twe_mon #(.PROG_CYCLES_P(PROG_CYCLES_P)) u_twe_mon (.i_clk, .i_srst, .i_scl,
  .i_sda, .i_wp, .i_strap_select_bit2, .i_strap_select_bit1, .i_strap_select_bit0, .o_sda_o,
  .o_sda_oe, .o_prog_busy);
`default_nettype wire
